//--- ref_b_profile_consts.svh
// Purpose: Constants for the reference B profile register bank of the first digital PLL.
// Assumes: Register indices are word indices; the bus byte address is four times the index.
// Notes: Included by the package and by both design modules.
`ifndef REF_B_PROFILE_CONSTS_SVH
`define REF_B_PROFILE_CONSTS_SVH

// Register indices as printed.
`define REF_B_SELECT_CFG_IDX 12'h44d
`define REF_B_BW_SCALE_LO_IDX 12'h44e
`define REF_B_BW_SCALE_MID_IDX 12'h44f
`define REF_B_BW_SCALE_HI_FILTER_IDX 12'h450
`define REF_B_INT_DIV_LO_IDX 12'h451
`define REF_B_INT_DIV_MID_IDX 12'h452
`define REF_B_INT_DIV_HI_IDX 12'h453
`define REF_B_FRAC_NUM_LO_IDX 12'h454
`define REF_B_FRAC_NUM_MID_IDX 12'h455
`define REF_B_FRAC_NUM_HI_IDX 12'h456
`define REF_B_FRAC_DEN_LO_IDX 12'h457
`define REF_B_FRAC_DEN_MID_IDX 12'h458
`define REF_B_FRAC_DEN_HI_IDX 12'h459
// Commit control and status register.
`define REF_B_APPLY_IDX 12'h4f0
`define PROFILE_BYTE_COUNT 13

// Relative positions inside the byte store.
`define POS_SELECT_CFG 4'h0
`define POS_BW_SCALE_HI_FILTER 4'h3
`define POS_INT_DIV_HI 4'h6

// Writable bit masks; reserved bits stay zero.
`define MASK_SELECT_CFG 8'h07
`define MASK_BW_SCALE_HI_FILTER 8'h03
`define MASK_INT_DIV_HI 8'h03
`define MASK_FULL_BYTE 8'hff

// Field positions.
`define SELECT_ENABLE_BIT 0
`define SELECT_PRIO_LSB 1
`define FILTER_HIGH_PM_BIT 1
`define BW_SCALE_BIT16 0
`define APPLY_GO_BIT 0
`define APPLY_PENDING_BIT 0

// Reset values.
`define BYTE_RESET 8'h00
`define WORD_RESET 32'h00000000

`endif

//--- ref_b_profile_pkg.sv
// Purpose: Types shared by the reference B profile register bank.
// Assumes: Constants come from the header.
// Notes: The profile struct is what the reference selector and loop consume.
`include "ref_b_profile_consts.svh"

package ref_b_profile_pkg;

	typedef enum logic [1:0] {
		prio_level0 = 2'b00,
		prio_level1 = 2'b01,
		prio_level2 = 2'b10,
		prio_level3 = 2'b11
	} ref_prio_e;

	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_read_wait = 2'b01
	} bus_state_e;

	typedef enum logic [1:0] {
		rd_mapped = 2'b00,
		rd_apply = 2'b01,
		rd_unmapped = 2'b10
	} read_kind_e;

	typedef struct packed {
		ref_prio_e priority_level;
		logic use_reference_input_b;
		logic [16:0] bw_scale;
		logic high_phase_margin;
		logic [17:0] integer_feedback_divider;
		logic [23:0] fractional_numerator;
		logic [23:0] fractional_modulus;
	} profile_s;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_s;

endpackage : ref_b_profile_pkg

//--- profile_byte_store.sv
// Purpose: Small byte store holding the staged profile bytes.
// Assumes: One write and one read per cycle on hclk.
// Notes: Read data is registered and forwards a same-cycle write to the same byte.
`include "ref_b_profile_consts.svh"
`timescale 1ns/1ps

module profile_byte_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `PROFILE_BYTE_COUNT
) (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic wr_en, // Write strobe.
	input wire logic [3:0] wr_pos, // Write position.
	input wire logic [WIDTH-1:0] wr_data, // Write data, already masked.
	input wire logic [3:0] rd_pos, // Read position.
	output logic [WIDTH-1:0] rd_data, // Registered read data.
	output logic [WIDTH*DEPTH-1:0] all_bytes // Every byte, low position lowest.
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (wr_en && (int'(wr_pos) < DEPTH)) begin
			mem_reg[wr_pos] <= wr_data;
		end
	end

	// Forwarding keeps a read right behind a write to the same byte from seeing stale data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data <= '0;
		end else if (wr_en && (wr_pos == rd_pos)) begin
			rd_data <= wr_data;
		end else if (int'(rd_pos) < DEPTH) begin
			rd_data <= mem_reg[rd_pos];
		end else begin
			rd_data <= '0;
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			all_bytes[i*WIDTH +: WIDTH] = mem_reg[i];
		end
	end

endmodule : profile_byte_store

//--- ref_b_profile_regs.sv
// Purpose: AHB-Lite register bank for the reference B profile of the first digital PLL.
// Assumes: Single word transfers; only the low byte of each word carries a register.
// Notes: Bytes are staged and reach the profile outputs only when software commits them.
`include "ref_b_profile_consts.svh"
`timescale 1ns/1ps

module ref_b_profile_regs (
	input wire logic hclk, // System clock, 40 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire ref_b_profile_pkg::ahb_req_s bus_req, // AHB-Lite request signals.
	output ref_b_profile_pkg::ahb_rsp_s bus_rsp, // AHB-Lite response signals.
	output ref_b_profile_pkg::profile_s profile, // Committed profile for the PLL.
	output logic frac_bypass, // Fractional divider disabled and bypassed.
	output logic commit_pending // A staged byte was written since the last commit.
);
	import ref_b_profile_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	function automatic logic idx_mapped(input logic [31:0] addr);
		logic [11:0] idx;
		idx = addr[13:2];
		idx_mapped = (addr[1:0] == 2'b00) && (addr[31:14] == 18'h00000) &&
			(idx >= `REF_B_SELECT_CFG_IDX) && (idx <= `REF_B_FRAC_DEN_HI_IDX);
	endfunction : idx_mapped

	function automatic logic idx_apply(input logic [31:0] addr);
		idx_apply = (addr[1:0] == 2'b00) && (addr[31:14] == 18'h00000) &&
			(addr[13:2] == `REF_B_APPLY_IDX);
	endfunction : idx_apply

	function automatic logic [3:0] idx_pos(input logic [31:0] addr);
		logic [11:0] rel;
		rel = addr[13:2] - `REF_B_SELECT_CFG_IDX;
		idx_pos = rel[3:0];
	endfunction : idx_pos

	// Reserved bits are never stored, so they always read as zero.
	function automatic logic [7:0] byte_mask(input logic [3:0] pos);
		case (pos)
			`POS_SELECT_CFG: byte_mask = `MASK_SELECT_CFG;
			`POS_BW_SCALE_HI_FILTER: byte_mask = `MASK_BW_SCALE_HI_FILTER;
			`POS_INT_DIV_HI: byte_mask = `MASK_INT_DIV_HI;
			default: byte_mask = `MASK_FULL_BYTE;
		endcase
	endfunction : byte_mask

	function automatic logic [7:0] byte_at(input logic [8*`PROFILE_BYTE_COUNT-1:0] flat, input int pos);
		byte_at = flat[pos*8 +: 8];
	endfunction : byte_at

	////////////////////////////////////////////////////////////////////////////////
	// Bus state.

	bus_state_e state_reg;
	read_kind_e rd_kind_reg;
	logic wr_byte_reg;
	logic wr_apply_reg;
	logic [3:0] wr_pos_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic pending_reg;
	profile_s profile_reg;
	logic frac_bypass_reg;

	logic addr_phase;
	logic [3:0] rd_pos;
	logic [7:0] mem_rdata;
	logic [8*`PROFILE_BYTE_COUNT-1:0] staged;
	logic commit_go;
	logic [7:0] wr_byte;
	profile_s staged_profile;

	assign addr_phase = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
	assign rd_pos = idx_pos(bus_req.haddr);
	assign commit_go = wr_apply_reg && bus_req.hwdata[`APPLY_GO_BIT];
	assign wr_byte = bus_req.hwdata[7:0] & byte_mask(wr_pos_reg);

	profile_byte_store #(
		.WIDTH(8),
		.DEPTH(`PROFILE_BYTE_COUNT)
	) u_store (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_byte_reg),
		.wr_pos(wr_pos_reg),
		.wr_data(wr_byte),
		.rd_pos(rd_pos),
		.rd_data(mem_rdata),
		.all_bytes(staged)
	);

	// Address phase capture; writes have no wait state, reads take one.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= bus_idle;
			rd_kind_reg <= rd_unmapped;
			wr_byte_reg <= 1'b0;
			wr_apply_reg <= 1'b0;
			wr_pos_reg <= 4'h0;
			hreadyout_reg <= 1'b1;
		end else begin
			wr_byte_reg <= 1'b0;
			wr_apply_reg <= 1'b0;
			case (state_reg)
				bus_idle: begin
					if (addr_phase && bus_req.hwrite) begin
						wr_byte_reg <= idx_mapped(bus_req.haddr);
						wr_apply_reg <= idx_apply(bus_req.haddr);
						wr_pos_reg <= rd_pos;
					end else if (addr_phase) begin
						if (idx_mapped(bus_req.haddr)) begin
							rd_kind_reg <= rd_mapped;
						end else if (idx_apply(bus_req.haddr)) begin
							rd_kind_reg <= rd_apply;
						end else begin
							rd_kind_reg <= rd_unmapped;
						end
						hreadyout_reg <= 1'b0;
						state_reg <= bus_read_wait;
					end
				end
				bus_read_wait: begin
					hreadyout_reg <= 1'b1;
					state_reg <= bus_idle;
				end
				default: begin
					hreadyout_reg <= 1'b1;
					state_reg <= bus_idle;
				end
			endcase
		end
	end

	// Read data is loaded at the end of the wait cycle; unmapped words read zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= `WORD_RESET;
		end else if (state_reg == bus_read_wait) begin
			case (rd_kind_reg)
				rd_mapped: hrdata_reg <= {24'h000000, mem_rdata};
				rd_apply: hrdata_reg <= {31'h00000000, pending_reg};
				default: hrdata_reg <= `WORD_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Staged bytes gathered into fields.

	// Single bits are picked straight from the flat store; whole bytes go through byte_at.
	always_comb begin
		staged_profile.priority_level =
			ref_prio_e'(staged[`SELECT_PRIO_LSB +: 2]);
		staged_profile.use_reference_input_b = staged[`SELECT_ENABLE_BIT];
		staged_profile.bw_scale = {staged[8 * 3 + `BW_SCALE_BIT16],
			byte_at(staged, 2), byte_at(staged, 1)};
		staged_profile.high_phase_margin = staged[8 * 3 + `FILTER_HIGH_PM_BIT];
		staged_profile.integer_feedback_divider = {staged[8 * 6 +: 2],
			byte_at(staged, 5), byte_at(staged, 4)};
		staged_profile.fractional_numerator = {byte_at(staged, 9),
			byte_at(staged, 8), byte_at(staged, 7)};
		staged_profile.fractional_modulus = {byte_at(staged, 12),
			byte_at(staged, 11), byte_at(staged, 10)};
	end

	// Committing all fields in one edge means the loop never sees a half-written divider.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			profile_reg <= '0;
			frac_bypass_reg <= 1'b1;
		end else if (commit_go) begin
			profile_reg <= staged_profile;
			frac_bypass_reg <= (staged_profile.fractional_modulus == 24'h000000);
		end
	end

	// A byte write marks the staging as pending; committing clears it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_reg <= 1'b0;
		end else if (wr_byte_reg) begin
			pending_reg <= 1'b1;
		end else if (commit_go) begin
			pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign bus_rsp = '{hrdata: hrdata_reg, hreadyout: hreadyout_reg, hresp: 1'b0};
	assign profile = profile_reg;
	assign frac_bypass = frac_bypass_reg;
	assign commit_pending = pending_reg;

endmodule : ref_b_profile_regs

//--- ref_b_profile_regs_monitor.sv
// Purpose: Port assertions for the reference B profile bank.
// Assumes: One slave on the bus, so hready follows hreadyout.
// Notes: Bound to every instance of ref_b_profile_regs.
`timescale 1ns/1ps
module ref_b_profile_regs_monitor import ref_b_profile_pkg::*; (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset, active low.
	input wire ahb_req_s bus_req, // Bus request.
	input wire ahb_rsp_s bus_rsp, // Bus response.
	input wire profile_s profile, // Committed profile.
	input wire logic frac_bypass, // Fraction bypassed.
	input wire logic commit_pending // Staged bytes waiting.
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic taken, wr_q, commit_now, map_q;
	logic [31:0] addr_q;
	assign taken = bus_req.hsel & bus_req.htrans[1] & bus_req.hready;
	assign commit_now = wr_q & (addr_q == 32'h000013c0) & bus_req.hwdata[0];
	assign map_q = wr_q & (addr_q[1:0] == 2'h0) & (addr_q >= 32'h00001134) & (addr_q <= 32'h00001164);
	// The data phase of a write follows its address edge by one cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 32'h0;
		end else begin
			wr_q <= taken & bus_req.hwrite;
			addr_q <= bus_req.haddr;
		end
	end
	property p_rd(logic [31:0] a, logic [31:0] m);
		taken && !bus_req.hwrite && bus_req.haddr == a |-> ##2 (bus_rsp.hrdata & m) == 32'h0;
	endproperty
	////////////////////////////////////////////////////////////
	a_bypass_mod: assert property (frac_bypass == (profile.fractional_modulus == 24'h0))
		else $error("bypass flag disagrees with modulus");
	a_profile_hold: assert property (!commit_now |=> $stable(profile))
		else $error("profile moved without a commit");
	a_commit_clears: assert property (commit_now |=> !commit_pending)
		else $error("pending flag kept after commit");
	a_write_pends: assert property (map_q |=> commit_pending)
		else $error("pending flag not set by byte write");
	a_sel_reserved: assert property (p_rd(32'h00001134, 32'hfffffff8))
		else $error("select byte reserved bits read nonzero");
	a_filt_reserved: assert property (p_rd(32'h00001140, 32'hfffffffc))
		else $error("filter byte reserved bits read nonzero");
	a_div_reserved: assert property (p_rd(32'h0000114c, 32'hfffffffc))
		else $error("divider top byte reserved bits read nonzero");
	a_unmapped_zero: assert property (taken && !bus_req.hwrite && bus_req.haddr[31:14] != 18'h0
		|-> ##2 bus_rsp.hrdata == 32'h0)
		else $error("unmapped read returned data");
	c_commit: cover property (commit_now);
	c_read: cover property (taken && !bus_req.hwrite);
	c_bypass: cover property ($rose(frac_bypass));
endmodule : ref_b_profile_regs_monitor

bind ref_b_profile_regs ref_b_profile_regs_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .bus_req(bus_req),
	.bus_rsp(bus_rsp), .profile(profile), .frac_bypass(frac_bypass), .commit_pending(commit_pending));

//--- ref_b_profile_regs_tb_top.sv
// Purpose: Self-checking bench for the reference B profile bank.
// Assumes: Reads take one wait state, writes none.
// Notes: Byte address is four times the register index.
`include "ref_b_profile_consts.svh"
`timescale 1ns/1ps
module ref_b_profile_regs_tb_top;
	import ref_b_profile_pkg::*;
	localparam int B = `REF_B_SELECT_CFG_IDX;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [1:0] trans = 2'h0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	ahb_req_s req;
	ahb_rsp_s rsp;
	profile_s prof;
	logic bypass, pending;
	int fail_count = 0;
	int total_checks = 0;
	logic [7:0] wv [13] = '{8'h00, 8'h34, 8'h12, 8'hff, 8'hcd, 8'hab, 8'hfe, 8'h01, 8'h02, 8'h03, 8'ha0, 8'hb0, 8'hc0};
	assign req = '{hsel: sel, haddr: addr, htrans: trans, hwrite: wr, hsize: 3'h2, hwdata: wdata,
		hready: rsp.hreadyout};
	always #12.5 hclk = ~hclk;
	ref_b_profile_regs DUT (.hclk(hclk), .hresetn(hresetn), .bus_req(req), .bus_rsp(rsp), .profile(prof),
		.frac_bypass(bypass), .commit_pending(pending));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [85:0] seen, input logic [85:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		sel <= 1'b1;
		trans <= 2'h2;
		addr <= a;
		wr <= w;
		@(posedge hclk);
		while (rsp.hreadyout !== 1'b1) @(posedge hclk);
		sel <= 1'b0;
		trans <= 2'h0;
		wdata <= d;
		@(posedge hclk);
		while (rsp.hreadyout !== 1'b1) @(posedge hclk);
		rdata = rsp.hrdata;
		// Outputs launched at the last data edge are only settled one edge later, so checks wait for it.
		@(posedge hclk);
	endtask : xfer
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask : rchk
	task automatic commit();
		xfer(1'b1, 4 * `REF_B_APPLY_IDX, 32'h1);
	endtask : commit
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		chk(prof, 86'h0);
		chk(bypass, 1'b1);
		for (int i = 0; i < 13; i++) rchk(4 * (B + i), 32'h0);
		for (int p = 0; p < 4; p++) begin
			xfer(1'b1, 4 * B, {24'h0, 5'h1f, p[1:0], 1'b1});
			chk(prof.priority_level, (p == 0) ? 0 : p - 1);
			rchk(4 * B, {29'h0, p[1:0], 1'b1});
			commit();
			chk(prof.priority_level, p);
			chk(prof.use_reference_input_b, 1'b1);
		end
		xfer(1'b1, 4 * B, 32'h0);
		commit();
		chk(prof.use_reference_input_b, 1'b0);
		// Factor 0x11234 is 7019.6 Hz: nonzero, above 50 Hz, above 2 kHz so the high margin filter is set.
		// The phase detector is taken to run well above twenty times that bandwidth.
		for (int i = 1; i < 13; i++) xfer(1'b1, 4 * (B + i), {24'h0, wv[i]});
		chk(pending, 1'b1);
		chk(prof.bw_scale, 17'h0);
		rchk(4 * `REF_B_APPLY_IDX, 32'h1);
		for (int i = 1; i < 13; i++) rchk(4 * (B + i), {24'h0, wv[i] & ((i == 3 || i == 6) ? 8'h03 : 8'hff)});
		commit();
		chk(pending, 1'b0);
		chk(prof.bw_scale, 17'h11234);
		chk(prof.high_phase_margin, 1'b1);
		chk(prof.integer_feedback_divider, 18'h2abcd);
		chk(prof.fractional_numerator, 24'h030201);
		chk(prof.fractional_modulus, 24'hc0b0a0);
		chk(bypass, 1'b0);
		xfer(1'b1, 4 * (B + 10), 32'h0);
		xfer(1'b1, 4 * (B + 11), 32'h0);
		chk(prof.fractional_modulus, 24'hc0b0a0);
		xfer(1'b1, 4 * (B + 12), 32'h0);
		commit();
		chk(bypass, 1'b1);
		// A misaligned write must not land on the register its word index points at.
		xfer(1'b1, 4 * (B + 1) + 1, 32'hff);
		rchk(4 * (B + 1), 32'h34);
		rchk(32'h00011138, 32'h0);
		chk(rsp.hresp, 1'b0);
		// A second reset in mid-run must drop staged and committed state alike.
		xfer(1'b1, 4 * (B + 1), 32'h5a);
		chk(pending, 1'b1);
		chk(prof.bw_scale, 17'h11234);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(prof, 86'h0);
		chk(bypass, 1'b1);
		chk(pending, 1'b0);
		rchk(4 * (B + 1), 32'h0);
		finish_test();
	end
	initial begin
		#(25 * 4000);
		fail_count++;
		finish_test();
	end
endmodule : ref_b_profile_regs_tb_top
